/* skc_ir_detect.sv */
`timescale 1ns/10ps
module skc_ir_detect
    import skc_pkg::*;
(
    input wire logic pclk, // Clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic ir_rx, // Selected IR receive line.
    input wire logic clear, // Status read pulse.
    output logic activity // Sticky activity flag.
);
    logic ir_prev;
    logic primed;
    logic next_activity;
    logic next_primed;

    always_comb begin
        next_primed = 1'b1;
        next_activity = activity;
        if (clear) begin
            next_activity = 1'b0;
        end
        // A fresh edge beats the clearing read, so an edge in the clearing cycle stays set.
        if (primed && (ir_rx != ir_prev)) begin
            next_activity = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_prev <= 1'b0;
            primed <= 1'b0;
            activity <= 1'b0;
        end else begin
            ir_prev <= ir_rx;
            primed <= next_primed;
            activity <= next_activity;
        end
    end

    a_ir_edge_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (primed && ir_rx != ir_prev) |=> activity)
        else $error("IR transition did not set activity");
endmodule : skc_ir_detect

/* skc_pkg.sv */
package skc_pkg;
    localparam logic [7:0] SKC_OFS_EN_A = 8'hb4;
    localparam logic [7:0] SKC_OFS_EN_B = 8'hb5;
    localparam logic [7:0] SKC_OFS_ST_A = 8'hb6;
    localparam logic [7:0] SKC_OFS_ST_B = 8'hb7;
    localparam logic [7:0] SKC_OFS_CTRL = 8'hf0;
    localparam logic [7:0] SKC_RSV_LO = 8'hf1;
    localparam logic [7:0] SKC_RSV_HI = 8'hff;
    localparam logic [7:0] SKC_MASK_A = 8'h9e;
    localparam logic [7:0] SKC_MASK_B = 8'h57;
    localparam logic [7:0] SKC_MASK_SRC_B = 8'h17;
    localparam logic [7:0] SKC_MASK_CTRL = 8'hfc;
    localparam logic [7:0] SKC_RST_EN_A = 8'h00;
    localparam logic [7:0] SKC_RST_EN_B = 8'h02;
    localparam logic [7:0] SKC_RST_CTRL = 8'h00;
    localparam int SKC_BIT_PAR = 1;
    localparam int SKC_BIT_UARTB = 2;
    localparam int SKC_BIT_UARTA = 3;
    localparam int SKC_BIT_FLOPPY = 4;
    localparam int SKC_BIT_WDOG = 7;
    localparam int SKC_BIT_MOUSE = 0;
    localparam int SKC_BIT_KBD = 1;
    localparam int SKC_BIT_IR = 2;
    localparam int SKC_BIT_P12 = 4;
    localparam int SKC_BIT_SERFRM = 6;
    localparam int SKC_BIT_POL = 7;
    localparam int SKC_BIT_MISO = 6;
    localparam int SKC_BIT_KISO = 5;
    localparam int SKC_BIT_MLAT = 4;
    localparam int SKC_BIT_KLAT = 3;
    localparam int SKC_BIT_P92 = 2;

    typedef struct packed {
        logic parallel_ack;
        logic parallel_active;
        logic uart_b_irq;
        logic uart_a_irq;
        logic floppy_irq;
        logic watchdog_irq;
    } skc_src_t;

    typedef struct packed {
        logic clk;
        logic data;
    } skc_ps_t;
endpackage : skc_pkg

/* skc_src_model.sv */
`timescale 1ns/10ps
module skc_src_model
    import skc_pkg::*;
(
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire skc_src_t want_src, // Requested peripheral levels.
    input wire logic [2:0] want_kc, // Requested mouse, keyboard, port bit.
    input wire logic want_ir, // Requested IR line level.
    output skc_src_t src, // Peripheral requests.
    output logic kc_mouse_irq, // Controller mouse interrupt.
    output logic kc_kbd_irq, // Controller keyboard interrupt.
    output logic kc_port_bit, // Controller port bit 1.2.
    output logic ir_rx // IR receive line.
);
    // Requests drop only here, at the source; software never clears them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src <= '0;
            {kc_mouse_irq, kc_kbd_irq, kc_port_bit} <= 3'h0;
            ir_rx <= 1'b0;
        end else begin
            src <= want_src;
            {kc_mouse_irq, kc_kbd_irq, kc_port_bit} <= want_kc;
            ir_rx <= want_ir;
        end
    end
endmodule : skc_src_model

/* skc_top.sv */
// Functional notes
// - Port bit 1.2 output is active low when polarity bit clear, high when set.
// - Mouse isolation blocks mouse clock and data into controller, not wake-up.
// - Keyboard isolation blocks keyboard clock and data into controller, not wake-up.
// - Mouse irq is raw AND latched, or latched alone when latch select set.
// - Keyboard irq is raw AND latched, or latched alone when latch select set.
// - Port 92 handling follows the port 92 select bit.
// - Indices 0xf1 through 0xff are reserved and read zero.
// - Enable A bits 1,2,3,4,7 gate parallel, uart b, uart a, floppy, watchdog.
// - Enable B bits 0,1,2,4 gate mouse, keyboard, IR activity, port bit.
// - Enable B bit 6 puts group SMI into the serial IRQ frame.
// - Keyboard enable bit resets to one.
// - Status A bits clear only when the source drops; writes do nothing.
// - Status A reports raw requests of the five sources.
// - Parallel status reads one while the port is not activated.
// - Parallel status follows the acknowledge input while activated.
// - Status B reports mouse, keyboard and port bit, cleared at source.
// - IR activity is set by any receive edge, cleared by status B read.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module skc_top
    import skc_pkg::*;
(
    input wire logic pclk, // Bus clock, 50 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [9:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire skc_src_t src, // Peripheral requests.
    input wire logic kc_mouse_irq, // Controller mouse interrupt.
    input wire logic kc_kbd_irq, // Controller keyboard interrupt.
    input wire logic kc_port_bit, // Controller port bit 1.2, true when asserted.
    input wire logic ir_rx, // Selected IR receive line.
    input wire skc_ps_t mouse_pins, // Mouse clock and data from pins.
    input wire skc_ps_t kbd_pins, // Keyboard clock and data from pins.
    output skc_ps_t mouse_to_kc, // Mouse lines into controller.
    output skc_ps_t kbd_to_kc, // Keyboard lines into controller.
    output logic mouse_data_wake, // Mouse data to wake-up logic.
    output logic keyboard_data_wake, // Keyboard data to wake-up logic.
    output logic controller_port_bit_1_2, // Port bit 1.2 with polarity applied.
    output logic mouse_interrupt, // Exported mouse interrupt.
    output logic keyboard_interrupt, // Exported keyboard interrupt.
    output logic port92_enable, // Port 92 handling enabled.
    output logic group_sysmgmt_irq_n, // Group SMI, active low.
    output logic smi_serial_frame // Request in serial IRQ SMI frame.
);
    logic [7:0] smi_source_enable_a;
    logic [7:0] smi_source_enable_b;
    logic [7:0] kbd_aux_control;
    logic mouse_latch_q;
    logic kbd_latch_q;
    logic [7:0] next_en_a;
    logic [7:0] next_en_b;
    logic [7:0] next_ctrl;
    logic next_mouse_latch;
    logic next_kbd_latch;
    logic [7:0] status_a;
    logic [7:0] status_b;
    logic ir_activity_status;
    logic ir_clear;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] rd_byte;
    logic mapped;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic mouse_export;
    logic kbd_export;
    logic next_smi_n;

    // Register index is the word address; the byte offsets are the indices.
    function automatic logic [7:0] skc_index(input logic [9:0] a);
        return a[9:2];
    endfunction : skc_index

    function automatic logic skc_hit(input logic [7:0] i);
        return (i == SKC_OFS_EN_A) || (i == SKC_OFS_EN_B) || (i == SKC_OFS_ST_A) ||
            (i == SKC_OFS_ST_B) || (i == SKC_OFS_CTRL) ||
            ((i >= SKC_RSV_LO) && (i <= SKC_RSV_HI));
    endfunction : skc_hit

    assign idx = skc_index(paddr);
    assign mapped = skc_hit(idx) && (paddr[1:0] == 2'b00);
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr = access && pwrite && mapped;
    assign rd = access && !pwrite;
    assign ir_clear = rd && mapped && (idx == SKC_OFS_ST_B);

    skc_ir_detect u_ir (
        .pclk(pclk),
        .presetn(presetn),
        .ir_rx(ir_rx),
        .clear(ir_clear),
        .activity(ir_activity_status)
    );

    // Status A is pure live state, so it clears only when the source drops.
    always_comb begin
        status_a = 8'h00;
        status_a[SKC_BIT_PAR] = src.parallel_active ? src.parallel_ack : 1'b1;
        status_a[SKC_BIT_UARTB] = src.uart_b_irq;
        status_a[SKC_BIT_UARTA] = src.uart_a_irq;
        status_a[SKC_BIT_FLOPPY] = src.floppy_irq;
        status_a[SKC_BIT_WDOG] = src.watchdog_irq;
        status_b = 8'h00;
        status_b[SKC_BIT_MOUSE] = mouse_export;
        status_b[SKC_BIT_KBD] = kbd_export;
        status_b[SKC_BIT_IR] = ir_activity_status;
        status_b[SKC_BIT_P12] = kc_port_bit;
    end

    always_comb begin
        mouse_export = kbd_aux_control[SKC_BIT_MLAT] ? mouse_latch_q
            : (kc_mouse_irq & mouse_latch_q);
        kbd_export = kbd_aux_control[SKC_BIT_KLAT] ? kbd_latch_q
            : (kc_kbd_irq & kbd_latch_q);
    end

    always_comb begin
        next_en_a = smi_source_enable_a;
        next_en_b = smi_source_enable_b;
        next_ctrl = kbd_aux_control;
        if (wr && idx == SKC_OFS_EN_A) begin
            next_en_a = pwdata[7:0] & SKC_MASK_A;
        end
        if (wr && idx == SKC_OFS_EN_B) begin
            next_en_b = pwdata[7:0] & SKC_MASK_B;
        end
        if (wr && idx == SKC_OFS_CTRL) begin
            next_ctrl = pwdata[7:0] & SKC_MASK_CTRL;
        end
        // The latch holds a request until the controller drops it.
        next_mouse_latch = kc_mouse_irq;
        next_kbd_latch = kc_kbd_irq;
        // Status writes are ignored; sources clear their own bits, except IR activity, which a status B read clears.
    end

    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            SKC_OFS_EN_A: rd_byte = smi_source_enable_a;
            SKC_OFS_EN_B: rd_byte = smi_source_enable_b;
            SKC_OFS_ST_A: rd_byte = status_a;
            SKC_OFS_ST_B: rd_byte = status_b & SKC_MASK_SRC_B;
            SKC_OFS_CTRL: rd_byte = kbd_aux_control;
            default: rd_byte = 8'h00;
        endcase
        next_pready = setup;
        next_pslverr = setup && !mapped;
        next_prdata = 32'h0000_0000;
        if (setup && !pwrite && mapped) begin
            next_prdata = {24'h00_0000, rd_byte};
        end
    end

    always_comb begin
        next_smi_n = !(|(status_a & smi_source_enable_a) ||
            |(status_b & smi_source_enable_b & SKC_MASK_SRC_B));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smi_source_enable_a <= SKC_RST_EN_A;
            smi_source_enable_b <= SKC_RST_EN_B;
            kbd_aux_control <= SKC_RST_CTRL;
            mouse_latch_q <= 1'b0;
            kbd_latch_q <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            smi_source_enable_a <= next_en_a;
            smi_source_enable_b <= next_en_b;
            kbd_aux_control <= next_ctrl;
            mouse_latch_q <= next_mouse_latch;
            kbd_latch_q <= next_kbd_latch;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mouse_to_kc <= '0;
            kbd_to_kc <= '0;
            mouse_data_wake <= 1'b0;
            keyboard_data_wake <= 1'b0;
            controller_port_bit_1_2 <= 1'b1;
            mouse_interrupt <= 1'b0;
            keyboard_interrupt <= 1'b0;
            port92_enable <= 1'b0;
            group_sysmgmt_irq_n <= 1'b1;
            smi_serial_frame <= 1'b0;
        end else begin
            // Isolated lines idle high, matching an undriven open-drain line.
            mouse_to_kc <= kbd_aux_control[SKC_BIT_MISO] ? 2'b11 : mouse_pins;
            kbd_to_kc <= kbd_aux_control[SKC_BIT_KISO] ? 2'b11 : kbd_pins;
            mouse_data_wake <= mouse_pins.data;
            keyboard_data_wake <= kbd_pins.data;
            controller_port_bit_1_2 <= kbd_aux_control[SKC_BIT_POL] ? kc_port_bit
                : !kc_port_bit;
            mouse_interrupt <= mouse_export;
            keyboard_interrupt <= kbd_export;
            port92_enable <= kbd_aux_control[SKC_BIT_P92];
            group_sysmgmt_irq_n <= next_smi_n;
            smi_serial_frame <= !next_smi_n && smi_source_enable_b[SKC_BIT_SERFRM];
        end
    end

    a_pol_low: assert property (@(posedge pclk) disable iff (!presetn)
        !kbd_aux_control[SKC_BIT_POL] && $stable(kbd_aux_control) |=>
        controller_port_bit_1_2 == !$past(kc_port_bit))
        else $error("port bit polarity wrong");
    a_pol_high: assert property (@(posedge pclk) disable iff (!presetn)
        kbd_aux_control[SKC_BIT_POL] |=> controller_port_bit_1_2 == $past(kc_port_bit))
        else $error("port bit active high polarity wrong");
    a_mouse_iso: assert property (@(posedge pclk) disable iff (!presetn)
        kbd_aux_control[SKC_BIT_MISO] |=> mouse_to_kc == 2'b11)
        else $error("mouse not isolated");
    a_kbd_iso: assert property (@(posedge pclk) disable iff (!presetn)
        kbd_aux_control[SKC_BIT_KISO] |=> kbd_to_kc == 2'b11)
        else $error("keyboard not isolated");
    // The releasing edge still finds the flops in reset, so sampled presetn keeps it out.
    a_mouse_pass: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && !kbd_aux_control[SKC_BIT_MISO] |=> mouse_to_kc == $past(mouse_pins))
        else $error("mouse lines not passed through");
    a_kbd_pass: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && !kbd_aux_control[SKC_BIT_KISO] |=> kbd_to_kc == $past(kbd_pins))
        else $error("keyboard lines not passed through");
    // Wake-up data must flow even while the controller side is isolated.
    a_mouse_wake: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> mouse_data_wake == $past(mouse_pins.data))
        else $error("mouse wake-up data blocked");
    a_kbd_wake: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> keyboard_data_wake == $past(kbd_pins.data))
        else $error("keyboard wake-up data blocked");
    a_mouse_latch: assert property (@(posedge pclk) disable iff (!presetn)
        !kbd_aux_control[SKC_BIT_MLAT] && !kc_mouse_irq |=> !mouse_interrupt)
        else $error("mouse interrupt not gated by raw");
    a_mouse_held: assert property (@(posedge pclk) disable iff (!presetn)
        kbd_aux_control[SKC_BIT_MLAT] && mouse_latch_q |=> mouse_interrupt)
        else $error("latched mouse interrupt lost");
    a_kbd_latch: assert property (@(posedge pclk) disable iff (!presetn)
        kbd_aux_control[SKC_BIT_KLAT] && kbd_latch_q |=> keyboard_interrupt)
        else $error("latched keyboard interrupt lost");
    a_kbd_and: assert property (@(posedge pclk) disable iff (!presetn)
        !kbd_aux_control[SKC_BIT_KLAT] && !kc_kbd_irq |=> !keyboard_interrupt)
        else $error("keyboard interrupt not gated by raw");
    a_p92_follow: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 port92_enable == $past(kbd_aux_control[SKC_BIT_P92]))
        else $error("port 92 enable mismatch");
    a_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && idx >= SKC_RSV_LO |=> pready && prdata == 32'h0)
        else $error("reserved index read not zero");
    a_stb_rsv: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && mapped && idx == SKC_OFS_ST_B |=> prdata[31:5] == 27'h0 && !prdata[3])
        else $error("reserved status B bit read as one");
    a_par_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && mapped && idx == SKC_OFS_ST_A && src.parallel_active
        |=> prdata[SKC_BIT_PAR] == $past(src.parallel_ack))
        else $error("parallel status does not follow acknowledge");
    a_wr_en_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == SKC_OFS_EN_A |=> smi_source_enable_a == ($past(pwdata[7:0]) & SKC_MASK_A))
        else $error("enable A write not stored");
    a_smi_assert: assert property (@(posedge pclk) disable iff (!presetn)
        src.watchdog_irq && smi_source_enable_a[SKC_BIT_WDOG] |=> !group_sysmgmt_irq_n)
        else $error("watchdog SMI not asserted");
    a_smi_kbd: assert property (@(posedge pclk) disable iff (!presetn)
        kbd_export && smi_source_enable_b[SKC_BIT_KBD] |=> !group_sysmgmt_irq_n)
        else $error("keyboard SMI not asserted");
    a_smi_ir: assert property (@(posedge pclk) disable iff (!presetn)
        ir_activity_status && smi_source_enable_b[SKC_BIT_IR] |=> !group_sysmgmt_irq_n)
        else $error("IR activity SMI not asserted");
    a_smi_idle: assert property (@(posedge pclk) disable iff (!presetn)
        smi_source_enable_a == 8'h00 && smi_source_enable_b == 8'h00
        |=> group_sysmgmt_irq_n)
        else $error("SMI asserted with nothing enabled");
    // With no status bit set at all, the group line has nothing to hold it low.
    a_smi_clear: assert property (@(posedge pclk) disable iff (!presetn)
        status_a == 8'h00 && status_b == 8'h00 |=> group_sysmgmt_irq_n)
        else $error("SMI asserted with no status set");
    a_ser_frame: assert property (@(posedge pclk) disable iff (!presetn)
        smi_serial_frame |-> !group_sysmgmt_irq_n && $past(smi_source_enable_b[SKC_BIT_SERFRM]))
        else $error("serial frame without enable");
    a_frame_off: assert property (@(posedge pclk) disable iff (!presetn)
        !smi_source_enable_b[SKC_BIT_SERFRM] |=> !smi_serial_frame)
        else $error("serial frame while frame enable clear");
    a_par_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !src.parallel_active |-> status_a[SKC_BIT_PAR])
        else $error("parallel status not one when inactive");
    a_ena_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (smi_source_enable_a & ~SKC_MASK_A) == 8'h00 && (kbd_aux_control & 8'h03) == 8'h00)
        else $error("reserved bit stored");
    a_enb_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (smi_source_enable_b & ~SKC_MASK_B) == 8'h00)
        else $error("reserved enable B bit stored");
endmodule : skc_top

/* skc_top_test.sv */
`timescale 1ns/10ps
module skc_top_test
    import skc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, kc_mouse_irq, kc_kbd_irq, kc_port_bit, ir_rx;
    skc_src_t want_src = '0;
    skc_src_t src;
    logic [2:0] want_kc = 3'h0;
    logic want_ir = 1'b0;
    skc_ps_t mouse_pins = '0;
    skc_ps_t kbd_pins = '0;
    skc_ps_t mouse_to_kc, kbd_to_kc;
    logic mouse_data_wake, keyboard_data_wake, controller_port_bit_1_2;
    logic mouse_interrupt, keyboard_interrupt, port92_enable;
    logic group_sysmgmt_irq_n, smi_serial_frame;
    int n_errors = 0;
    int samples_checked = 0;
    logic [7:0] abit [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
    logic [5:0] avec [5] = '{6'h30, 6'h18, 6'h14, 6'h12, 6'h11};
    logic [7:0] bbit [3] = '{8'h01, 8'h02, 8'h10};
    logic [2:0] bvec [3] = '{3'h4, 3'h2, 3'h1};

    always #10 pclk = ~pclk;

    skc_src_model skc_src_model_inst (.pclk(pclk), .presetn(presetn),
        .want_src(want_src), .want_kc(want_kc), .want_ir(want_ir), .src(src),
        .kc_mouse_irq(kc_mouse_irq), .kc_kbd_irq(kc_kbd_irq),
        .kc_port_bit(kc_port_bit), .ir_rx(ir_rx));

    skc_top skc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
        .kc_mouse_irq(kc_mouse_irq), .kc_kbd_irq(kc_kbd_irq),
        .kc_port_bit(kc_port_bit), .ir_rx(ir_rx), .mouse_pins(mouse_pins),
        .kbd_pins(kbd_pins), .mouse_to_kc(mouse_to_kc), .kbd_to_kc(kbd_to_kc),
        .mouse_data_wake(mouse_data_wake), .keyboard_data_wake(keyboard_data_wake),
        .controller_port_bit_1_2(controller_port_bit_1_2),
        .mouse_interrupt(mouse_interrupt), .keyboard_interrupt(keyboard_interrupt),
        .port92_enable(port92_enable), .group_sysmgmt_irq_n(group_sysmgmt_irq_n),
        .smi_serial_frame(smi_serial_frame));

    task conclude;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            n_errors++;
        end
    endtask : chk

    // Bus signals change only just after a rising edge and are held until pready.
    task apb(input logic w, input logic [7:0] a, input logic [7:0] wd,
             output logic [7:0] rd, output logic er);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            conclude();
        end
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] d;
        logic e;
        apb(1'b1, a, v, d, e);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] x, input string nm);
        logic [7:0] d;
        logic e;
        apb(1'b0, a, 8'h00, d, e);
        chk(nm, x, d);
        chk("pslverr", 8'h00, {7'h0, e});
    endtask : rd

    task wt(input int c);
        repeat (c) @(posedge pclk);
    endtask : wt

    task t_reset;
        rd(SKC_OFS_EN_A, 8'h00, "en_a");
        rd(SKC_OFS_EN_B, 8'h02, "en_b");
        rd(SKC_OFS_ST_A, 8'h02, "st_a idle");
        rd(SKC_OFS_ST_B, 8'h00, "st_b");
        rd(SKC_OFS_CTRL, 8'h00, "ctrl");
        chk("port bit", 8'h01, {7'h0, controller_port_bit_1_2});
        chk("smi_n", 8'h01, {7'h0, group_sysmgmt_irq_n});
    endtask : t_reset

    task t_status_a;
        want_src <= 6'h3f;
        wt(3);
        rd(SKC_OFS_ST_A, 8'h9e, "st_a all");
        wr(SKC_OFS_ST_A, 8'h00);
        rd(SKC_OFS_ST_A, 8'h9e, "st_a kept");
        want_src <= 6'h10;
        wt(3);
        rd(SKC_OFS_ST_A, 8'h00, "st_a low ack");
    endtask : t_status_a

    task t_gate_a;
        for (int i = 0; i < 5; i++) begin
            wr(SKC_OFS_EN_A, ~abit[i] & 8'h9e);
            want_src <= avec[i];
            wt(3);
            chk("smi_n other", 8'h01, {7'h0, group_sysmgmt_irq_n});
            wr(SKC_OFS_EN_A, abit[i]);
            wt(3);
            chk("smi_n on", 8'h00, {7'h0, group_sysmgmt_irq_n});
            want_src <= 6'h10;
            wt(3);
            chk("smi_n off", 8'h01, {7'h0, group_sysmgmt_irq_n});
        end
        wr(SKC_OFS_EN_A, 8'h00);
    endtask : t_gate_a

    task t_gate_b;
        for (int i = 0; i < 3; i++) begin
            wr(SKC_OFS_EN_B, bbit[i] | 8'h40);
            want_kc <= bvec[i];
            wt(3);
            rd(SKC_OFS_ST_B, bbit[i], "st_b src");
            chk("smi_n b", 8'h00, {7'h0, group_sysmgmt_irq_n});
            chk("frame on", 8'h01, {7'h0, smi_serial_frame});
            wr(SKC_OFS_EN_B, bbit[i]);
            wt(3);
            chk("frame off", 8'h00, {7'h0, smi_serial_frame});
            want_kc <= 3'h0;
            wt(3);
            chk("smi_n b off", 8'h01, {7'h0, group_sysmgmt_irq_n});
        end
    endtask : t_gate_b

    task t_ir;
        wr(SKC_OFS_EN_B, 8'h04);
        want_ir <= 1'b1;
        // The edge detector adds a stage, so the group line answers a cycle later.
        wt(4);
        chk("smi_n ir", 8'h00, {7'h0, group_sysmgmt_irq_n});
        rd(SKC_OFS_ST_B, 8'h04, "ir set");
        rd(SKC_OFS_ST_B, 8'h00, "ir cleared");
        wt(3);
        chk("smi_n ir off", 8'h01, {7'h0, group_sysmgmt_irq_n});
    endtask : t_ir

    task t_ctrl;
        kbd_pins <= 2'b01;
        wr(SKC_OFS_CTRL, 8'hff);
        rd(SKC_OFS_CTRL, 8'hfc, "ctrl rsv");
        want_kc <= 3'h6;
        // The latch stage sits in front of the exported interrupt flop.
        wt(4);
        chk("mouse iso", 8'h03, {6'h0, mouse_to_kc});
        chk("kbd iso", 8'h03, {6'h0, kbd_to_kc});
        chk("kbd wake", 8'h01, {7'h0, keyboard_data_wake});
        chk("mouse wake", 8'h00, {7'h0, mouse_data_wake});
        chk("p92 on", 8'h01, {7'h0, port92_enable});
        chk("port hi pol", 8'h00, {7'h0, controller_port_bit_1_2});
        chk("mouse_interrupt latch", 8'h01, {7'h0, mouse_interrupt});
        chk("keyboard_interrupt latch", 8'h01, {7'h0, keyboard_interrupt});
        wr(SKC_OFS_CTRL, 8'h00);
        wt(3);
        chk("mouse pass", 8'h00, {6'h0, mouse_to_kc});
        chk("kbd pass", 8'h01, {6'h0, kbd_to_kc});
        chk("p92 off", 8'h00, {7'h0, port92_enable});
        chk("port lo pol", 8'h01, {7'h0, controller_port_bit_1_2});
        chk("mouse_interrupt and", 8'h01, {7'h0, mouse_interrupt});
        want_kc <= 3'h0;
        wt(3);
        chk("mouse_interrupt low", 8'h00, {7'h0, mouse_interrupt});
        chk("keyboard_interrupt low", 8'h00, {7'h0, keyboard_interrupt});
    endtask : t_ctrl

    task t_rsv;
        logic [7:0] d;
        logic e;
        rd(SKC_RSV_LO, 8'h00, "rsv lo");
        wr(SKC_RSV_HI, 8'h5a);
        rd(SKC_RSV_HI, 8'h00, "rsv hi");
        wr(SKC_OFS_EN_A, 8'hff);
        rd(SKC_OFS_EN_A, SKC_MASK_A, "en_a rsv");
        wr(SKC_OFS_EN_B, 8'hff);
        rd(SKC_OFS_EN_B, SKC_MASK_B, "en_b rsv");
        wr(SKC_OFS_EN_A, 8'h00);
        wr(SKC_OFS_EN_B, 8'h00);
        apb(1'b0, 8'h00, 8'h00, d, e);
        chk("unmapped err", 8'h01, {7'h0, e});
    endtask : t_rsv

    task t_rerun;
        wr(SKC_OFS_CTRL, 8'h84);
        presetn <= 1'b0;
        wt(2);
        chk("port bit rst", 8'h01, {7'h0, controller_port_bit_1_2});
        presetn <= 1'b1;
        wt(1);
        rd(SKC_OFS_EN_B, 8'h02, "en_b again");
        rd(SKC_OFS_CTRL, 8'h00, "ctrl again");
        chk("p92 rst", 8'h00, {7'h0, port92_enable});
    endtask : t_rerun

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_status_a();
        t_gate_a();
        t_gate_b();
        t_ir();
        t_ctrl();
        t_rsv();
        t_rerun();
        conclude();
    end
endmodule : skc_top_test
